// ### fflr_pkg.sv
// Purpose: Constants for the fault flag live and latched readback block
// Assumes: Wishbone classic slave, byte-wide registers in the low data bits
// Notes: Printed offsets are register indices; byte address is four times the index
package fflr_pkg;
    // Register indices
    localparam logic [7:0] IDX_LIVE_TEMP = 8'h47;
    localparam logic [7:0] IDX_LIVE_BROWN = 8'h48;
    localparam logic [7:0] IDX_STK_PROT = 8'h49;
    localparam logic [7:0] IDX_STK_CRC = 8'h4a;
    localparam logic [7:0] IDX_STK_PLL = 8'h4b;
    localparam logic [7:0] IDX_STK_TEMP = 8'h4f;
    localparam logic [7:0] IDX_STK_BROWN = 8'h50;
    localparam logic [7:0] IDX_CLK_TYPE = 8'h51;
    localparam logic [7:0] IDX_CTRL = 8'h5c;
    localparam logic [7:0] IDX_MASK_PROT = 8'h3b;
    localparam logic [7:0] IDX_MASK_CRC = 8'h3c;
    localparam logic [7:0] IDX_MASK_PLL = 8'h3d;
    localparam logic [7:0] IDX_MASK_TEMP = 8'h40;
    localparam logic [7:0] IDX_MASK_BROWN = 8'h41;
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_PROT_RESET = 8'hfc;
    localparam logic [7:0] MASK_CRC_RESET = 8'hbe;
    localparam logic [7:0] MASK_PLL_RESET = 8'hdf;
    localparam logic [7:0] MASK_TEMP_RESET = 8'hf6;
    localparam logic [7:0] MASK_BROWN_RESET = 8'h00;
    localparam logic [1:0] PIN_MODE_RESET = 2'h1;
    // Valid bits of partly reserved registers
    localparam logic [7:0] CRC_VALID = 8'h78;
    localparam logic [7:0] PLL_VALID = 8'ha0;
    localparam logic [7:0] CLK_TYPE_VALID = 8'h07;
    // Control register fields
    localparam int CTRL_CLEAR_BIT = 2;
    localparam int CTRL_MODE_LSB = 0;
    // Latched load diagnostic fault byte fields and protection byte clock error bit
    localparam int DIAG_DONE_BIT = 5;
    localparam int DIAG_CODE_LSB = 3;
    localparam int CLK_ERR_BIT = 2;
    // Pin pulse timing
    localparam int CLK_HZ = 20000000;
    localparam int PULSE_MS = 2;
    localparam int PERIOD_MS = 4;
    localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
    localparam int PERIOD_CYCLES = CLK_HZ / 1000 * PERIOD_MS;
    // Pin assertion modes
    typedef enum logic [1:0] {
        MODE_LIVE,
        MODE_LATCHED,
        MODE_LIVE_PULSE,
        MODE_LATCHED_REPEAT
    } fflr_mode_e;
endpackage

// ### fflr_top.sv
// Purpose: Live and latched fault flag readback with interrupt pin driver
// Assumes: Event inputs are synchronous to clk_i; 20 MHz clock
// Notes: Pin pulse counts are parameters so simulation can shorten them
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module fflr_top #(
    parameter int PULSE_CYCLES = fflr_pkg::PULSE_CYCLES,
    parameter int PERIOD_CYCLES = fflr_pkg::PERIOD_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Live temperature and supply events
    input wire logic [3:0] temp_over_i,
    input wire logic [2:0] regulator_fault_i,
    input wire logic power_stage_lockout_i,
    // Live brownout and thermal events
    input wire logic [1:0] thermal_threshold_i,
    input wire logic supply_gap_low_i,
    input wire logic brownout_active_i,
    input wire logic [3:0] brownout_level_i,
    // Protection events for latching
    input wire logic [7:0] protection_event_i,
    input wire logic [2:0] clock_error_type_i,
    input wire logic fuse_crc_error_i,
    input wire logic load_diag_done_i,
    input wire logic [1:0] load_diag_fault_code_i,
    input wire logic pll_clock_error_i,
    input wire logic battery_undervoltage_i,
    // Interrupt pin, active low
    output logic interrupt_request_pin_n_o
);

    // Repeat mode needs the pulse to fit inside its period
    if (PULSE_CYCLES < 1 || PERIOD_CYCLES <= PULSE_CYCLES) begin : g_bad_timing
        $error("Pulse must be at least one cycle and shorter than the period");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Live and event vectors

    logic [7:0] live_temp;
    logic [7:0] live_brown;
    logic [7:0] ev_crc;
    logic [7:0] ev_pll;
    logic [7:0] ev_clk_type;

    assign live_temp = {temp_over_i,
                        regulator_fault_i,
                        power_stage_lockout_i};
    assign live_brown = {thermal_threshold_i,
                         supply_gap_low_i,
                         brownout_active_i,
                         brownout_level_i};
    // Reserved positions forced to zero here and again in the latch
    assign ev_crc = {1'b0,
                     fuse_crc_error_i,
                     load_diag_done_i,
                     load_diag_fault_code_i,
                     3'h0};
    assign ev_pll = {pll_clock_error_i,
                     1'b0,
                     battery_undervoltage_i,
                     5'h00};
    // Type is only recorded together with the clock error itself
    assign ev_clk_type = protection_event_i[fflr_pkg::CLK_ERR_BIT] ?
                         {5'h00, clock_error_type_i} : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic req;
    logic [7:0] idx;
    logic wr_ctrl;
    logic wr_byte;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign idx = wb_adr_i[9:2];
    // Only byte lane zero carries register data
    assign wr_byte = req && wb_we_i && wb_sel_i[0];
    assign wr_ctrl = wr_byte && idx == fflr_pkg::IDX_CTRL;

    ////////////////////////////////////////////////////////////////////////////
    // Live registers, registered once for clean readback

    logic [7:0] live_temp_reg;
    logic [7:0] live_brown_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            live_temp_reg <= fflr_pkg::STATUS_RESET;
        end else begin
            live_temp_reg <= live_temp;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            live_brown_reg <= fflr_pkg::STATUS_RESET;
        end else begin
            live_brown_reg <= live_brown;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control: clear bit, pin mode

    logic clear_reg;
    logic [1:0] pin_mode_reg;

    // Self-clearing: stands one cycle, then the latches hold only the events present in that cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clear_reg <= 1'b0;
        end else begin
            clear_reg <= wr_ctrl && wb_dat_i[fflr_pkg::CTRL_CLEAR_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_mode_reg <= fflr_pkg::PIN_MODE_RESET;
        end else if (wr_ctrl) begin
            pin_mode_reg <= wb_dat_i[fflr_pkg::CTRL_MODE_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latched registers: set wins over clear

    logic [7:0] ev_all [6];
    logic [7:0] stk_reg [6];
    logic [7:0] stk_valid [6];

    assign ev_all[0] = protection_event_i;
    assign ev_all[1] = ev_crc;
    assign ev_all[2] = ev_pll;
    assign ev_all[3] = live_temp;
    assign ev_all[4] = live_brown;
    assign ev_all[5] = ev_clk_type;
    assign stk_valid[0] = 8'hff;
    assign stk_valid[1] = fflr_pkg::CRC_VALID;
    assign stk_valid[2] = fflr_pkg::PLL_VALID;
    assign stk_valid[3] = 8'hff;
    assign stk_valid[4] = 8'hff;
    assign stk_valid[5] = fflr_pkg::CLK_TYPE_VALID;

    // Event in the clear cycle sets again, so no event is lost
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_stk
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    stk_reg[g] <= fflr_pkg::STATUS_RESET;
                end else if (clear_reg) begin
                    stk_reg[g] <= ev_all[g] & stk_valid[g];
                end else begin
                    stk_reg[g] <= (stk_reg[g] | ev_all[g]) & stk_valid[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Mask registers

    logic [7:0] mask_reg [5];
    logic [7:0] mask_idx [5];
    logic [7:0] mask_rst [5];

    assign mask_idx[0] = fflr_pkg::IDX_MASK_PROT;
    assign mask_idx[1] = fflr_pkg::IDX_MASK_CRC;
    assign mask_idx[2] = fflr_pkg::IDX_MASK_PLL;
    assign mask_idx[3] = fflr_pkg::IDX_MASK_TEMP;
    assign mask_idx[4] = fflr_pkg::IDX_MASK_BROWN;
    assign mask_rst[0] = fflr_pkg::MASK_PROT_RESET;
    assign mask_rst[1] = fflr_pkg::MASK_CRC_RESET;
    assign mask_rst[2] = fflr_pkg::MASK_PLL_RESET;
    assign mask_rst[3] = fflr_pkg::MASK_TEMP_RESET;
    assign mask_rst[4] = fflr_pkg::MASK_BROWN_RESET;

    generate
        for (g = 0; g < 5; g++) begin : g_mask
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    mask_reg[g] <= mask_rst[g];
                end else if (wr_byte && idx == mask_idx[g]) begin
                    mask_reg[g] <= wb_dat_i[7:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt sources

    logic live_any;
    logic latched_any;
    logic [7:0] live_unmasked [5];
    logic [7:0] stk_unmasked [5];

    // Live bytes for latched-only sources reuse the raw event vectors
    assign live_unmasked[0] = protection_event_i & ~mask_reg[0];
    assign live_unmasked[1] = ev_crc & ~mask_reg[1];
    assign live_unmasked[2] = ev_pll & ~mask_reg[2];
    assign live_unmasked[3] = live_temp_reg & ~mask_reg[3];
    assign live_unmasked[4] = live_brown_reg & ~mask_reg[4];
    generate
        for (g = 0; g < 5; g++) begin : g_unm
            assign stk_unmasked[g] = stk_reg[g] & ~mask_reg[g];
        end
    endgenerate
    assign live_any = |{live_unmasked[0],
                        live_unmasked[1],
                        live_unmasked[2],
                        live_unmasked[3],
                        live_unmasked[4]};
    assign latched_any = |{stk_unmasked[0],
                           stk_unmasked[1],
                           stk_unmasked[2],
                           stk_unmasked[3],
                           stk_unmasked[4]};

    ////////////////////////////////////////////////////////////////////////////
    // Pin timing

    logic live_any_reg;
    logic [31:0] pulse_cnt_reg;
    logic [31:0] period_cnt_reg;
    logic pin_n_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            live_any_reg <= 1'b0;
        end else begin
            live_any_reg <= live_any;
        end
    end

    // Free-running period, so repeat pulses keep a fixed rhythm
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_cnt_reg <= 32'h0000_0000;
        end else if (period_cnt_reg >= 32'(PERIOD_CYCLES - 1)) begin
            period_cnt_reg <= 32'h0000_0000;
        end else begin
            period_cnt_reg <= period_cnt_reg + 32'h0000_0001;
        end
    end

    // One pulse per rising live event, not retriggered while running
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_cnt_reg <= 32'h0000_0000;
        end else if (live_any && !live_any_reg && pulse_cnt_reg == 32'h0000_0000) begin
            pulse_cnt_reg <= 32'(PULSE_CYCLES);
        end else if (pulse_cnt_reg != 32'h0000_0000) begin
            pulse_cnt_reg <= pulse_cnt_reg - 32'h0000_0001;
        end
    end

    // Active low, held inactive through reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_n_reg <= 1'b1;
        end else begin
            case (fflr_pkg::fflr_mode_e'(pin_mode_reg))
                fflr_pkg::MODE_LIVE: pin_n_reg <= !live_any;
                fflr_pkg::MODE_LATCHED: pin_n_reg <= !latched_any;
                fflr_pkg::MODE_LIVE_PULSE: begin
                    pin_n_reg <= pulse_cnt_reg == 32'h0000_0000;
                end
                fflr_pkg::MODE_LATCHED_REPEAT: begin
                    pin_n_reg <= !(latched_any && period_cnt_reg < 32'(PULSE_CYCLES));
                end
                default: pin_n_reg <= 1'b1;
            endcase
        end
    end

    assign interrupt_request_pin_n_o = pin_n_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait-free cycle, writes to status ignored

    logic [7:0] rd_byte;
    logic hit;

    always_comb begin
        rd_byte = 8'h00;
        hit = 1'b1;
        case (idx)
            fflr_pkg::IDX_LIVE_TEMP: rd_byte = live_temp_reg;
            fflr_pkg::IDX_LIVE_BROWN: rd_byte = live_brown_reg;
            fflr_pkg::IDX_STK_PROT: rd_byte = stk_reg[0];
            fflr_pkg::IDX_STK_CRC: rd_byte = stk_reg[1];
            fflr_pkg::IDX_STK_PLL: rd_byte = stk_reg[2];
            fflr_pkg::IDX_STK_TEMP: rd_byte = stk_reg[3];
            fflr_pkg::IDX_STK_BROWN: rd_byte = stk_reg[4];
            fflr_pkg::IDX_CLK_TYPE: rd_byte = stk_reg[5];
            fflr_pkg::IDX_CTRL: rd_byte = {5'h00, clear_reg, pin_mode_reg};
            fflr_pkg::IDX_MASK_PROT: rd_byte = mask_reg[0];
            fflr_pkg::IDX_MASK_CRC: rd_byte = mask_reg[1];
            fflr_pkg::IDX_MASK_PLL: rd_byte = mask_reg[2];
            fflr_pkg::IDX_MASK_TEMP: rd_byte = mask_reg[3];
            fflr_pkg::IDX_MASK_BROWN: rd_byte = mask_reg[4];
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && hit;
        end
    end

    // Unmapped index answers with an error instead of silence
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_err_o <= 1'b0;
        end else begin
            wb_err_o <= req && !hit;
        end
    end

    // Zero outside read answers keeps stale status off the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && hit && !wb_we_i) begin
            wb_dat_o <= {24'h000000, rd_byte};
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

endmodule

// ### fflr_top_chk.sv
// Purpose: Port-level assertions for the fault flag readback block
// Assumes: Single clock domain, synchronous active high reset
// Notes: Live values are compared only while the input held still
`timescale 1ns/10ps
module fflr_top_chk #(
    parameter int PULSE_CYCLES = 4,
    parameter int PERIOD_CYCLES = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // Live events and pin
    input wire logic [3:0] temp_over_i,
    input wire logic [2:0] regulator_fault_i,
    input wire logic power_stage_lockout_i,
    input wire logic [1:0] thermal_threshold_i,
    input wire logic supply_gap_low_i,
    input wire logic brownout_active_i,
    input wire logic [3:0] brownout_level_i,
    input wire logic interrupt_request_pin_n_o
);
    logic req;
    logic rd;
    logic [7:0] idx;
    logic [7:0] live1;
    logic [7:0] live2;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign rd = req && !wb_we_i;
    assign idx = wb_adr_i[9:2];
    assign live1 = {temp_over_i, regulator_fault_i, power_stage_lockout_i};
    assign live2 = {thermal_threshold_i, supply_gap_low_i, brownout_active_i, brownout_level_i};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////
    a_req_answered: assert property (req |=> (wb_ack_o || wb_err_o))
        else $error("request not answered in one cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    // Reset edge excluded: the live copy is still cleared there
    a_live_temp_read: assert property (rd && idx == fflr_pkg::IDX_LIVE_TEMP
        && !$past(rst_i) && $stable(live1) |=> wb_dat_o == {24'h0, $past(live1)})
        else $error("live temperature byte wrong");
    a_live_brown_read: assert property (rd && idx == fflr_pkg::IDX_LIVE_BROWN
        && !$past(rst_i) && $stable(live2) |=> wb_dat_o == {24'h0, $past(live2)})
        else $error("live brownout byte wrong");
    a_dat_upper_zero: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    a_crc_reserved: assert property (rd && idx == 8'h4a |=> (wb_dat_o[7:0] & 8'h87) == 8'h0)
        else $error("reserved crc bits set");
    a_pll_reserved: assert property (rd && idx == 8'h4b |=> (wb_dat_o[7:0] & 8'h5f) == 8'h0)
        else $error("reserved pll bits set");
    a_pin_reset_idle: assert property ($fell(rst_i) |-> interrupt_request_pin_n_o)
        else $error("pin active after reset");
    c_read_ack: cover property (rd && idx == 8'h49 ##1 wb_ack_o);
    c_err: cover property (wb_err_o);
    c_pin_low: cover property (!interrupt_request_pin_n_o);
endmodule
bind fflr_top fflr_top_chk #(.PULSE_CYCLES(PULSE_CYCLES), .PERIOD_CYCLES(PERIOD_CYCLES)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .temp_over_i(temp_over_i), .regulator_fault_i(regulator_fault_i),
    .power_stage_lockout_i(power_stage_lockout_i), .thermal_threshold_i(thermal_threshold_i),
    .supply_gap_low_i(supply_gap_low_i), .brownout_active_i(brownout_active_i),
    .brownout_level_i(brownout_level_i), .interrupt_request_pin_n_o(interrupt_request_pin_n_o));

// ### tb_top.sv
// Purpose: Self-checking bench for the fault flag readback block
// Assumes: Byte register at index times four, answer within a few cycles
// Notes: Pin pulse counts shortened through parameters
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic [15:0] v;
        logic [7:0] e47;
        logic [7:0] e48;
    } fflr_row_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    logic pin_n;
    logic [15:0] live = 16'h0;
    logic [16:0] lat = 17'h0;
    logic [7:0] rd;
    logic er;
    logic [7:0] n_low;
    int n_errors = 0;
    int n_checks = 0;
    logic [7:0] stat [7] = '{8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4f, 8'h50};
    fflr_row_s rows [4] = '{'{16'h8421, 8'h84, 8'h21}, '{16'h7e90, 8'h7e, 8'h90},
        '{16'h0160, 8'h01, 8'h60}, '{16'hff0f, 8'hff, 8'h0f}};
    always #25 clk_i = ~clk_i;
    fflr_top #(.PULSE_CYCLES(4), .PERIOD_CYCLES(8)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .temp_over_i(live[15:12]), .regulator_fault_i(live[11:9]),
        .power_stage_lockout_i(live[8]), .thermal_threshold_i(live[7:6]),
        .supply_gap_low_i(live[5]), .brownout_active_i(live[4]), .brownout_level_i(live[3:0]),
        .protection_event_i(lat[16:9]), .clock_error_type_i(lat[8:6]),
        .fuse_crc_error_i(lat[5]), .load_diag_done_i(lat[4]),
        .load_diag_fault_code_i(lat[3:2]), .pll_clock_error_i(lat[1]),
        .battery_undervoltage_i(lat[0]), .interrupt_request_pin_n_o(pin_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until ack or err is sampled high
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 16);
        if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
            n_errors++;
            stop_test();
        end
        rd = wb_dat_o[7:0];
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h0);
        chk(rd, exp);
    endtask
    // Mode bits kept at latched mode while clearing
    task automatic clr();
        bus(1'b1, 8'h5c, 8'h05);
        bus(1'b0, 8'h5c, 8'h00);
        chk(rd & 8'h07, 8'h01);
        rdc(8'h49, 8'h00);
    endtask
    task automatic pulse(input logic [15:0] l, input logic [16:0] p);
        @(posedge clk_i);
        live <= l;
        lat <= p;
        @(posedge clk_i);
        live <= 16'h0;
        lat <= 17'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (stat[i]) rdc(stat[i], 8'h00);
        chk({7'h0, pin_n}, 8'h01);
        bus(1'b1, 8'h49, 8'hff);
        rdc(8'h49, 8'h00);
        bus(1'b1, 8'h4a, 8'hff);
        rdc(8'h4a, 8'h00);
        foreach (rows[i]) begin
            @(posedge clk_i);
            live <= rows[i].v;
            rdc(8'h47, rows[i].e47);
            rdc(8'h48, rows[i].e48);
        end
        live <= 16'h0;
        rdc(8'h4f, 8'hff);
        rdc(8'h50, 8'hff);
        clr();
        rdc(8'h4f, 8'h00);
        pulse(16'h0, {8'ha5, 3'b101, 6'h00});
        rdc(8'h49, 8'ha5);
        rdc(8'h51, 8'h05);
        chk({7'h0, pin_n}, 8'h00);
        clr();
        chk({7'h0, pin_n}, 8'h01);
        pulse(16'h0, {8'h80, 9'h000});
        rdc(8'h49, 8'h80);
        chk({7'h0, pin_n}, 8'h01);
        // Unmasking an event already latched drives the pin
        bus(1'b1, 8'h3b, 8'h7f);
        rdc(8'h3b, 8'h7f);
        chk({7'h0, pin_n}, 8'h00);
        // Reset in mid-run empties latches and restores masks
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(8'h49, 8'h00);
        rdc(8'h3b, 8'hfc);
        chk({7'h0, pin_n}, 8'h01);
        pulse(16'h0, 17'h0003b);
        rdc(8'h4a, 8'h70);
        rdc(8'h4b, 8'ha0);
        clr();
        pulse(16'h0, 17'h00004);
        rdc(8'h4a, 8'h08);
        // Live mode follows the registered live byte
        bus(1'b1, 8'h5c, 8'h00);
        live <= 16'h0001;
        rdc(8'h48, 8'h01);
        chk({7'h0, pin_n}, 8'h00);
        // Condition still present after the clear keeps its latch
        clr();
        rdc(8'h50, 8'h01);
        live <= 16'h0;
        // Single pulse mode ignores the standing latched flag
        bus(1'b1, 8'h5c, 8'h02);
        @(posedge clk_i);
        chk({7'h0, pin_n}, 8'h01);
        pulse(16'h0001, 17'h0);
        repeat (3) @(posedge clk_i);
        chk({7'h0, pin_n}, 8'h00);
        repeat (8) @(posedge clk_i);
        chk({7'h0, pin_n}, 8'h01);
        // Repeat mode: low for four of every eight cycles
        bus(1'b1, 8'h5c, 8'h03);
        n_low = 8'h00;
        @(posedge clk_i);
        repeat (16) begin
            @(posedge clk_i);
            if (pin_n === 1'b0) begin
                n_low++;
            end
        end
        chk(n_low, 8'h08);
        clr();
        bus(1'b0, 8'h00, 8'h00);
        chk({7'h0, er}, 8'h01);
        stop_test();
    end
endmodule
